// ==== usm_top.sv ====
// Behaviour
// - with address detect clear, every received word is buffered and flagged unless the buffer is full or overrun is set
// - half duplex: receive inhibits transmit; transmit never inhibits receive
// - sync select, port enable and clock source bit together turn the two pins into clock and data lines
// - clock source bit makes this device drive the shift clock
// - shift register reloads only after last bit, then at once from buffer
// - buffer to shift transfer takes one cycle, then buffer-empty flag sets
// - buffer-empty flag also sets when transmit enable rises on an empty buffer, clears only on buffer write
// - shift-register-empty status bit reads one while shift register is empty
// - transmit enable arms; shifting starts only once the buffer holds data
// - first bit goes out on next rising clock; data stable at falling edges
// - baud generator held reset while all three enables are clear
// - write with empty shift register moves straight in; words go back to back
// - clearing transmit enable aborts, resets transmitter, releases data pin; clock pin too unless a receive enable is set
// - receive enable aborts transmit, releases data pin, keeps clock, no reset
// - after single-word receive, hardware clears it and transmit resumes
// - ninth transmit bit is latched at the buffer to shift transfer
// - the transmit shift register has no bus address
// - receive-ready sets on buffered word, clears when buffer read empty
module usm_top
   import usm_pkg::*;
#(
   parameter int RX_DEPTH = 2
)(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // serial pins
   input wire logic shift_clock_line_i,
   input wire logic serial_data_line_i,
   output usm_pin_t shift_clock_line,
   output usm_pin_t serial_data_line
);
`include "usm_regs.svh"

   localparam int PW = $clog2(RX_DEPTH);
   // a macro literal cannot be sliced, so the reset word is held here
   localparam logic [7:0] TX_CTL_RST = `USM_RST_TX_CTL;

   // ==========================================
   // elaboration checks
   if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("RX_DEPTH must be a power of two, at least 2");
   end

   // ==========================================
   // state
   logic dp_wr_q, dp_rd_q;
   logic [9:0] dp_idx_q;
   logic [31:0] hrdata_q;
   logic [7:0] int_ctl_q, per_en_q, baud_q, tx_buf_q, rdata;
   logic port_en_q, rx_nine_q, sgl_rx_q, cont_rx_q, adr_det_q;
   logic clk_mst_q, tx_nine_q, tx_en_q, sync_q, hi_speed_q, tx_bit9_q;
   logic tx_full_q, tx_empty_flag_q, tx_en_d1_q, overrun_q;
   logic [7:0] baud_cnt_q;
   logic sclk_q, dout_q;
   usm_tx_state_t tx_state_q;
   logic [8:0] tx_shift_q, rx_shift_q;
   logic [3:0] tx_cnt_q, rx_cnt_q;
   logic clk_s1_q, clk_s2_q, clk_s3_q, dat_s1_q, dat_s2_q;
   usm_rxword_t rx_mem [RX_DEPTH];
   logic [PW-1:0] rx_wp_q, rx_rp_q;
   logic [PW:0] rx_cnt_w_q;

   // ==========================================
   // decode and derived terms
   logic ap_take, wr_any, wr_tx_buf, wr_rx_ctl, rd_pop;
   logic run, master, tx_go, rx_mode, rise, fall, line_fall;
   logic load, rx_done, rx_keep, rx_push;
   logic [3:0] tx_bits, rx_bits;
   logic [8:0] rx_next;
   usm_rxword_t rx_word;

   assign ap_take = hsel & hready & htrans[1];
   assign wr_any = dp_wr_q;
   assign wr_tx_buf = wr_any && dp_idx_q == `USM_IDX_TX_BUF;
   assign wr_rx_ctl = wr_any && dp_idx_q == `USM_IDX_RX_CTL;
   assign rd_pop = dp_rd_q && dp_idx_q == `USM_IDX_RX_BUF && rx_cnt_w_q != '0;
   // baud generator runs on any enable
   assign run = tx_en_q | cont_rx_q | sgl_rx_q;
   assign master = port_en_q & sync_q & clk_mst_q;
   assign rx_mode = cont_rx_q | sgl_rx_q;
   // receive wins the line; transmit just freezes
   assign tx_go = master & tx_en_q & ~rx_mode;
   assign rise = master & run & baud_cnt_q == '0 & ~sclk_q;
   assign fall = master & run & baud_cnt_q == '0 & sclk_q;
   assign line_fall = clk_s3_q & ~clk_s2_q;
   assign tx_bits = tx_nine_q ? 4'd9 : 4'd8;
   assign rx_bits = rx_nine_q ? 4'd9 : 4'd8;
   assign load = tx_state_q == TXS_EMPTY && tx_full_q && tx_en_q;
   assign rx_next = {dat_s2_q, rx_shift_q[8:1]};
   assign rx_done = master & rx_mode & line_fall & (rx_cnt_q + 4'd1 == rx_bits);
   assign rx_word.bit9 = rx_nine_q & rx_next[8];
   assign rx_word.dat = rx_nine_q ? rx_next[7:0] : rx_next[8:1];
   // in nine-bit receive, address detect drops words with a clear ninth bit
   assign rx_keep = ~(adr_det_q & rx_nine_q & ~rx_word.bit9);
   assign rx_push = rx_done & rx_keep & ~overrun_q & rx_cnt_w_q != RX_DEPTH[PW:0];

   // ==========================================
   // ahb address and data phase
   // reads take one wait state so a write just before is visible
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_wr_q <= 1'b0;
         dp_rd_q <= 1'b0;
         dp_idx_q <= '0;
         hrdata_q <= '0;
      end
      else
      begin
         dp_wr_q <= ap_take & hwrite;
         if (dp_rd_q)
         begin
            hrdata_q <= {24'h000000, rdata};
            dp_rd_q <= 1'b0;
         end
         else
         begin
            dp_rd_q <= ap_take & ~hwrite;
         end
         if (ap_take)
         begin
            dp_idx_q <= haddr[11:2];
         end
      end
   end
   assign hreadyout = ~dp_rd_q;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   // ==========================================
   // read mux; shift registers have no index
   always_comb
   begin
      rdata = 8'h00;
      case (dp_idx_q)
         `USM_IDX_INT_CTL: rdata = int_ctl_q;
         `USM_IDX_PER_FLG:
         begin
            rdata[`USM_B_RX_READY] = rx_cnt_w_q != '0;
            rdata[`USM_B_TX_EMPTY] = tx_empty_flag_q;
         end
         `USM_IDX_RX_CTL:
         begin
            rdata[`USM_B_PORT_EN] = port_en_q;
            rdata[`USM_B_RX_NINE] = rx_nine_q;
            rdata[`USM_B_SGL_RX] = sgl_rx_q;
            rdata[`USM_B_CONT_RX] = cont_rx_q;
            rdata[`USM_B_ADR_DET] = adr_det_q;
            rdata[`USM_B_OVERRUN] = overrun_q;
            // empty buffer reads zero; storage has no reset value
            rdata[`USM_B_RX_BIT9] = rx_cnt_w_q != '0 && rx_mem[rx_rp_q].bit9;
         end
         `USM_IDX_TX_BUF: rdata = tx_buf_q;
         `USM_IDX_RX_BUF: rdata = (rx_cnt_w_q != '0) ? rx_mem[rx_rp_q].dat : 8'h00;
         `USM_IDX_PER_EN: rdata = per_en_q;
         `USM_IDX_TX_CTL:
         begin
            rdata[`USM_B_CLK_MST] = clk_mst_q;
            rdata[`USM_B_TX_NINE] = tx_nine_q;
            rdata[`USM_B_TX_EN] = tx_en_q;
            rdata[`USM_B_SYNC] = sync_q;
            rdata[`USM_B_HI_SPEED] = hi_speed_q;
            rdata[`USM_B_SR_EMPTY] = tx_state_q == TXS_EMPTY;
            rdata[`USM_B_TX_BIT9] = tx_bit9_q;
         end
         `USM_IDX_BAUD: rdata = baud_q;
         default: rdata = 8'h00;
      endcase
   end

   // ==========================================
   // plain software registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         int_ctl_q <= `USM_RST_ZERO;
         per_en_q <= `USM_RST_ZERO;
         baud_q <= `USM_RST_ZERO;
         {clk_mst_q, tx_nine_q, tx_en_q, sync_q} <= TX_CTL_RST[7:4];
         hi_speed_q <= TX_CTL_RST[`USM_B_HI_SPEED];
         tx_bit9_q <= TX_CTL_RST[`USM_B_TX_BIT9];
         {port_en_q, rx_nine_q, cont_rx_q, adr_det_q} <= 4'h0;
      end
      else if (wr_any)
      begin
         case (dp_idx_q)
            `USM_IDX_INT_CTL: int_ctl_q <= hwdata[7:0];
            `USM_IDX_PER_EN: per_en_q <= hwdata[7:0] & `USM_PER_EN_MASK;
            `USM_IDX_BAUD: baud_q <= hwdata[7:0];
            `USM_IDX_TX_CTL:
            begin
               clk_mst_q <= hwdata[`USM_B_CLK_MST];
               tx_nine_q <= hwdata[`USM_B_TX_NINE];
               tx_en_q <= hwdata[`USM_B_TX_EN];
               sync_q <= hwdata[`USM_B_SYNC];
               hi_speed_q <= hwdata[`USM_B_HI_SPEED];
               tx_bit9_q <= hwdata[`USM_B_TX_BIT9];
            end
            `USM_IDX_RX_CTL:
            begin
               port_en_q <= hwdata[`USM_B_PORT_EN];
               rx_nine_q <= hwdata[`USM_B_RX_NINE];
               cont_rx_q <= hwdata[`USM_B_CONT_RX];
               adr_det_q <= hwdata[`USM_B_ADR_DET];
            end
            default: ;
         endcase
      end
   end

   // single receive: software write wins over the hardware clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         sgl_rx_q <= 1'b0;
      else if (wr_rx_ctl)
         sgl_rx_q <= hwdata[`USM_B_SGL_RX];
      else if (rx_done && !cont_rx_q)
         sgl_rx_q <= 1'b0;
   end

   // ==========================================
   // transmit buffer and its empty flag
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_buf_q <= `USM_RST_ZERO;
         tx_full_q <= 1'b0;
         tx_empty_flag_q <= 1'b0;
         tx_en_d1_q <= 1'b0;
      end
      else
      begin
         tx_en_d1_q <= tx_en_q;
         if (wr_tx_buf)
         begin
            tx_buf_q <= hwdata[7:0];
            tx_full_q <= 1'b1;
            tx_empty_flag_q <= 1'b0;
         end
         else if (load)
         begin
            tx_full_q <= 1'b0;
            tx_empty_flag_q <= 1'b1;
         end
         else if (tx_en_q && !tx_en_d1_q && !tx_full_q)
         begin
            tx_empty_flag_q <= 1'b1;
         end
      end
   end

   // ==========================================
   // baud generator; half period is divisor + 1 cycles
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         baud_cnt_q <= '0;
         sclk_q <= 1'b0;
      end
      else if (!run)
      begin
         baud_cnt_q <= '0;
         sclk_q <= 1'b0;
      end
      else if (baud_cnt_q == '0)
      begin
         baud_cnt_q <= baud_q;
         sclk_q <= ~sclk_q;
      end
      else
      begin
         baud_cnt_q <= baud_cnt_q - 8'd1;
      end
   end

   // ==========================================
   // transmit shifter; bits change on rising clock only
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_state_q <= TXS_EMPTY;
         tx_shift_q <= '0;
         tx_cnt_q <= '0;
         dout_q <= 1'b0;
      end
      else if (!tx_en_q)
      begin
         tx_state_q <= TXS_EMPTY;
         tx_cnt_q <= '0;
         dout_q <= 1'b0;
      end
      else
      begin
         case (tx_state_q)
            TXS_EMPTY:
            begin
               if (load)
               begin
                  tx_state_q <= TXS_SHIFT;
                  // a rise in the load cycle carries bit 0, else that pulse goes out empty
                  if (tx_go && rise)
                  begin
                     dout_q <= tx_buf_q[0];
                     tx_shift_q <= {1'b0, tx_bit9_q, tx_buf_q[7:1]};
                     tx_cnt_q <= 4'd1;
                  end
                  else
                  begin
                     tx_shift_q <= {tx_bit9_q, tx_buf_q};
                     tx_cnt_q <= '0;
                  end
               end
            end
            TXS_SHIFT:
            begin
               if (tx_go && rise && tx_cnt_q != tx_bits)
               begin
                  dout_q <= tx_shift_q[0];
                  tx_shift_q <= {1'b0, tx_shift_q[8:1]};
                  tx_cnt_q <= tx_cnt_q + 4'd1;
               end
               else if (tx_go && fall && tx_cnt_q == tx_bits)
               begin
                  tx_state_q <= TXS_EMPTY;
               end
            end
            default: tx_state_q <= TXS_EMPTY;
         endcase
      end
   end

   // ==========================================
   // pin synchronisers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         {clk_s1_q, clk_s2_q, clk_s3_q} <= 3'b000;
         {dat_s1_q, dat_s2_q} <= 2'b00;
      end
      else
      begin
         clk_s1_q <= shift_clock_line_i;
         clk_s2_q <= clk_s1_q;
         clk_s3_q <= clk_s2_q;
         dat_s1_q <= serial_data_line_i;
         dat_s2_q <= dat_s1_q;
      end
   end

   // ==========================================
   // receive shifter, sampled at falling edges seen on the line
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rx_shift_q <= '0;
         rx_cnt_q <= '0;
      end
      else if (!master || !rx_mode)
      begin
         rx_cnt_q <= '0;
      end
      else if (rx_done)
      begin
         rx_cnt_q <= '0;
         rx_shift_q <= '0;
      end
      else if (line_fall)
      begin
         rx_shift_q <= rx_next;
         rx_cnt_q <= rx_cnt_q + 4'd1;
      end
   end

   // ==========================================
   // receive buffer and overrun; clearing continuous receive resets it
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rx_wp_q <= '0;
         rx_rp_q <= '0;
         rx_cnt_w_q <= '0;
         overrun_q <= 1'b0;
      end
      else
      begin
         if (!cont_rx_q)
            overrun_q <= 1'b0;
         else if (rx_done && rx_keep && rx_cnt_w_q == RX_DEPTH[PW:0])
            overrun_q <= 1'b1;
         if (rx_push)
            rx_wp_q <= rx_wp_q + 1'b1;
         if (rd_pop)
            rx_rp_q <= rx_rp_q + 1'b1;
         if (rx_push && !rd_pop)
            rx_cnt_w_q <= rx_cnt_w_q + 1'b1;
         else if (rd_pop && !rx_push)
            rx_cnt_w_q <= rx_cnt_w_q - 1'b1;
      end
   end

   // storage needs no reset
   always_ff @(posedge hclk)
   begin
      if (rx_push)
         rx_mem[rx_wp_q] <= rx_word;
   end

   // ==========================================
   // pin drivers
   assign shift_clock_line.lvl = sclk_q;
   assign shift_clock_line.oe = master & run;
   assign serial_data_line.lvl = dout_q;
   assign serial_data_line.oe = tx_go;

   // ==========================================
   // checks
   logic [8:0] half_q;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         half_q <= '0;
      else if (!run || baud_cnt_q == '0)
         half_q <= '0;
      else
         half_q <= half_q + 9'd1;
   end

   sequence s_load;
      tx_state_q == TXS_EMPTY && tx_full_q && tx_en_q && !wr_tx_buf;
   endsequence
   sequence s_sgl_done;
      rx_done && sgl_rx_q && !cont_rx_q && !wr_rx_ctl;
   endsequence

   AST_LOAD_ONE_CYCLE: assert property (@(posedge hclk) disable iff (!hresetn)
      s_load |=> tx_state_q == TXS_SHIFT && !tx_full_q && tx_empty_flag_q)
      else $error("buffer to shift transfer not done in one cycle");
   AST_FLAG_CLEAR_ON_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_tx_buf |=> !tx_empty_flag_q && tx_full_q)
      else $error("buffer-empty flag not cleared by write");
   AST_NO_SHIFT_EMPTY: assert property (@(posedge hclk) disable iff (!hresetn)
      tx_state_q == TXS_EMPTY && !tx_full_q && !wr_tx_buf |=> tx_state_q == TXS_EMPTY)
      else $error("shifting started with no data");
   AST_BAUD_HELD: assert property (@(posedge hclk) disable iff (!hresetn)
      !run |-> !shift_clock_line.oe ##1 (!sclk_q && baud_cnt_q == '0))
      else $error("baud generator not held in reset");
   AST_HALF_PERIOD: assert property (@(posedge hclk) disable iff (!hresetn)
      run && $stable(baud_q) && baud_cnt_q == '0 && $past(run) && half_q != '0
      |-> half_q == {1'b0, baud_q})
      else $error("shift clock half period wrong");
   AST_TRANSMIT_ENABLE_ABORT: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(tx_en_q) |-> !serial_data_line.oe ##1 tx_state_q == TXS_EMPTY)
      else $error("transmit not aborted on enable clear");
   AST_RX_RELEASE: assert property (@(posedge hclk) disable iff (!hresetn)
      rx_mode |-> !serial_data_line.oe ##1 (rx_mode || !tx_en_q || serial_data_line.oe))
      else $error("data pin driven during reception");
   AST_SGL_RESUME: assert property (@(posedge hclk) disable iff (!hresetn)
      s_sgl_done ##0 tx_en_q && master |=> !sgl_rx_q && serial_data_line.oe)
      else $error("transmit not resumed after single receive");
   AST_ADDR_FILTER: assert property (@(posedge hclk) disable iff (!hresetn)
      rx_done && adr_det_q && rx_nine_q && !rx_word.bit9 && !rd_pop |=> $stable(rx_cnt_w_q))
      else $error("word with clear ninth bit was buffered");
   AST_READ_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
      dp_rd_q |-> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
endmodule

// ==== usm_regs.svh ====
`ifndef USM_REGS_SVH
`define USM_REGS_SVH
// ==========================================
// register indices, byte address = 4 * index
`define USM_IDX_INT_CTL 10'h00b
`define USM_IDX_PER_FLG 10'h00c
`define USM_IDX_RX_CTL 10'h018
`define USM_IDX_TX_BUF 10'h019
`define USM_IDX_RX_BUF 10'h01a
`define USM_IDX_PER_EN 10'h08c
`define USM_IDX_TX_CTL 10'h098
`define USM_IDX_BAUD 10'h099
// ==========================================
// peripheral flag and enable fields
`define USM_B_RX_READY 5
`define USM_B_TX_EMPTY 4
`define USM_PER_EN_MASK 8'h7f
// ==========================================
// receive status and control fields
`define USM_B_PORT_EN 7
`define USM_B_RX_NINE 6
`define USM_B_SGL_RX 5
`define USM_B_CONT_RX 4
`define USM_B_ADR_DET 3
`define USM_B_FRAME_ERR 2
`define USM_B_OVERRUN 1
`define USM_B_RX_BIT9 0
// ==========================================
// transmit status and control fields
`define USM_B_CLK_MST 7
`define USM_B_TX_NINE 6
`define USM_B_TX_EN 5
`define USM_B_SYNC 4
`define USM_B_HI_SPEED 2
`define USM_B_SR_EMPTY 1
`define USM_B_TX_BIT9 0
// ==========================================
// reset values
`define USM_RST_ZERO 8'h00
`define USM_RST_TX_CTL 8'h02
`endif

// ==== usm_pkg.sv ====
package usm_pkg;
   // ==========================================
   // pin drive pair
   typedef struct packed {
      logic lvl;
      logic oe;
   } usm_pin_t;
   // one received word as buffered
   typedef struct packed {
      logic bit9;
      logic [7:0] dat;
   } usm_rxword_t;
   typedef enum logic [0:0] {TXS_EMPTY, TXS_SHIFT} usm_tx_state_t;
endpackage

// ==== usm_partner.sv ====
module usm_partner
   import usm_pkg::*;
(
   // system clock and bench control
   input wire logic hclk,
   input wire logic clr,
   input wire logic [35:0] stream,
   // resolved pins and device drive
   input wire logic ck,
   input wire logic dt,
   input wire usm_pin_t ck_dev,
   input wire usm_pin_t dt_dev,
   // own drive and capture
   output logic dt_lvl,
   output logic dt_oe,
   output logic [15:0] cap,
   output int cnt
);
   // ==========================================
   // far-side shift device
   logic ck_q;
   logic fell;
   int idx;
   // drive data only while the device listens and clocks
   assign dt_oe = ck_dev.oe && !dt_dev.oe;
   assign dt_lvl = (idx < 36) ? stream[idx] : 1'b1;
   // edges found on hclk: new bit after each rise that follows a fall, so it is stable at the fall
   always @(posedge hclk)
   begin
      ck_q <= ck;
      if (!dt_oe)
         idx <= 0;
      else if (ck && !ck_q && fell)
         idx <= idx + 1;
      if (!dt_oe)
         fell <= 1'b0;
      else if (!ck && ck_q)
         fell <= 1'b1;
      // device bits land lsb first at each fall
      if (!ck && ck_q && dt_dev.oe)
      begin
         cap <= {dt, cap[15:1]};
         cnt <= cnt + 1;
      end
      if (clr)
         cnt <= 0;
   end
endmodule

// ==== tb_usm_top.sv ====
`include "usm_regs.svh"
module tb_usm_top
   import usm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // bench signals
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [31:0] hwdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic clr;
   logic [35:0] stream;
   usm_pin_t ck_pin;
   usm_pin_t dt_pin;
   logic p_lvl;
   logic p_oe;
   logic [15:0] cap;
   int cnt;
   int num_errors = 0;
   int compares = 0;
   logic [7:0] v;
   logic [9:0] ridx [9] = '{`USM_IDX_INT_CTL, `USM_IDX_PER_FLG, `USM_IDX_RX_CTL,
      `USM_IDX_TX_BUF, `USM_IDX_RX_BUF, `USM_IDX_PER_EN, `USM_IDX_TX_CTL, `USM_IDX_BAUD, 10'h3ff};
   // clock pin pulled down, data pin pulled up when nobody drives
   wire ck = ck_pin.oe ? ck_pin.lvl : 1'b0;
   wire dt = dt_pin.oe ? dt_pin.lvl : (p_oe ? p_lvl : 1'b1);
   wire [15:0] oes = {14'h0, ck_pin.oe, dt_pin.oe};

   usm_top #(.RX_DEPTH(2)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .shift_clock_line_i(ck),
      .serial_data_line_i(dt), .shift_clock_line(ck_pin), .serial_data_line(dt_pin));
   usm_partner u_partner (.hclk(hclk), .clr(clr), .stream(stream), .ck(ck), .dt(dt),
      .ck_dev(ck_pin), .dt_dev(dt_pin), .dt_lvl(p_lvl), .dt_oe(p_oe), .cap(cap), .cnt(cnt));

   // 100 MHz system clock
   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // ==========================================
   // tasks
   task automatic wrap_up();
      $display("counts: %0d compares, %0d mismatches", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // every wait is bounded; running out is a failure
   task automatic guard(inout int n, input int lim);
      n++;
      if (n > lim)
      begin
         num_errors++;
         wrap_up();
      end
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
      begin
         guard(n, 50);
         @(posedge hclk);
      end
   endtask
   // one single word transfer, address held until hready, data taken at its end
   task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {idx, 2'h0};
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      wait_ready();
      v = hrdata[7:0];
   endtask
   task automatic wr(input logic [9:0] i, input logic [7:0] d);
      bus(1'b1, i, d);
   endtask
   task automatic rd(input logic [9:0] i, input logic [7:0] e, input logic [7:0] m = 8'hff);
      bus(1'b0, i, 8'h0);
      chk({15'h0, hresp}, 16'h0);
      chk({8'h0, v & m}, {8'h0, e & m});
   endtask
   task automatic poll(input logic [9:0] i, input logic [7:0] m, input logic [7:0] e);
      int n;
      n = 0;
      bus(1'b0, i, 8'h0);
      while ((v & m) !== e)
      begin
         guard(n, 400);
         bus(1'b0, i, 8'h0);
      end
   endtask
   task automatic wait_bits(input int b);
      int n;
      n = 0;
      while (cnt != b)
      begin
         guard(n, 1000);
         @(posedge hclk);
      end
   endtask
   task automatic wait_ck(input logic b);
      int n;
      n = 0;
      while (ck !== b)
      begin
         guard(n, 100);
         @(posedge hclk);
      end
   endtask
   task automatic pulse_clr();
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
   endtask
   // ==========================================
   // main sequence
   initial
   begin
      int n;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 12'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      clr = 1'b1;
      stream = 36'hfffffffa3;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      clr <= 1'b0;
      // reset values, unmapped place, masked bit
      foreach (ridx[k])
         rd(ridx[k], (k == 6) ? 8'h02 : 8'h00);
      wr(10'h3ff, 8'h55);
      rd(10'h3ff, 8'h00);
      wr(`USM_IDX_PER_EN, 8'hff);
      rd(`USM_IDX_PER_EN, 8'h7f);
      wr(`USM_IDX_BAUD, 8'h07);
      rd(`USM_IDX_BAUD, 8'h07);
      $display("test registers done");
      // transmit: loaded before enable, then a second word back to back
      wr(`USM_IDX_RX_CTL, 8'h80);
      wr(`USM_IDX_TX_CTL, 8'h30);
      @(posedge hclk);
      chk(oes & 16'h2, 16'h0);
      wr(`USM_IDX_TX_CTL, 8'h90);
      wr(`USM_IDX_TX_BUF, 8'ha5);
      wr(`USM_IDX_TX_CTL, 8'hb0);
      wait_ck(1'b1);
      n = 0;
      while (ck === 1'b1)
      begin
         guard(n, 20);
         @(posedge hclk);
      end
      chk(16'(n), 16'h8);
      wr(`USM_IDX_TX_BUF, 8'h3c);
      rd(`USM_IDX_PER_FLG, 8'h00);
      rd(`USM_IDX_TX_CTL, 8'hb0);
      wait_bits(16);
      chk(cap, 16'h3ca5);
      poll(`USM_IDX_TX_CTL, 8'h02, 8'h02);
      rd(`USM_IDX_PER_FLG, 8'h10);
      wr(`USM_IDX_PER_FLG, 8'h00);
      rd(`USM_IDX_PER_FLG, 8'h10);
      wr(`USM_IDX_TX_CTL, 8'h90);
      @(posedge hclk);
      chk(oes, 16'h0);
      $display("test transmit done");
      // nine bits: ninth bit written ahead of the byte
      pulse_clr();
      wr(`USM_IDX_TX_CTL, 8'hd1);
      wr(`USM_IDX_TX_BUF, 8'h96);
      wr(`USM_IDX_TX_CTL, 8'hf1);
      wait_bits(9);
      chk({7'h0, cap[15:7]}, 16'h0196);
      wr(`USM_IDX_TX_CTL, 8'h90);
      $display("test nine bit done");
      // address detect: word without ninth bit dropped, then detect cleared
      stream <= {9'h1ff, 9'h024, 9'h142, 9'h011};
      wr(`USM_IDX_RX_CTL, 8'hc0);
      wr(`USM_IDX_RX_CTL, 8'hc8);
      wr(`USM_IDX_RX_CTL, 8'hd8);
      poll(`USM_IDX_PER_FLG, 8'h20, 8'h20);
      rd(`USM_IDX_RX_CTL, 8'h01, 8'h01);
      rd(`USM_IDX_RX_BUF, 8'h42);
      wr(`USM_IDX_RX_CTL, 8'hd0);
      poll(`USM_IDX_PER_FLG, 8'h20, 8'h20);
      rd(`USM_IDX_RX_BUF, 8'h24);
      wr(`USM_IDX_RX_CTL, 8'h80);
      rd(`USM_IDX_RX_CTL, 8'h80, 8'hfe);
      $display("test address detect done");
      // single receive cuts into a transmission, then transmit resumes
      stream <= 36'hfffffffa3;
      pulse_clr();
      wr(`USM_IDX_TX_BUF, 8'h55);
      wr(`USM_IDX_TX_CTL, 8'hb0);
      wait_bits(3);
      wait_ck(1'b1);
      wr(`USM_IDX_RX_CTL, 8'ha0);
      @(posedge hclk);
      chk(oes, 16'h2);
      poll(`USM_IDX_RX_CTL, 8'h20, 8'h00);
      chk(oes, 16'h3);
      rd(`USM_IDX_PER_FLG, 8'h20, 8'h20);
      rd(`USM_IDX_RX_BUF, 8'ha3);
      rd(`USM_IDX_PER_FLG, 8'h00, 8'h20);
      wr(`USM_IDX_TX_CTL, 8'h90);
      @(posedge hclk);
      chk(oes, 16'h0);
      $display("test single receive done");
      wrap_up();
   end
endmodule
